// ===== mss_pkg.sv
// package for the memory size select register block
// assumes a 16-bit cpu data address space with byte-wide register access
package mss_pkg;

	localparam logic [15:0] MSS_REG_ADDR   = 16'hFFF0;
	localparam logic [7:0]  MSS_RESET_VAL  = 8'hCF;
	localparam logic [7:0]  MSS_WRITE_MASK = 8'hEF;

	// field positions
	localparam int MSS_RAM_MSB = 7;
	localparam int MSS_RAM_LSB = 5;
	localparam int MSS_ZERO_BIT = 4;
	localparam int MSS_ROM_MSB = 3;
	localparam int MSS_ROM_LSB = 0;

	// ram capacity codes
	localparam logic [2:0] MSS_RAM_512  = 3'h2;
	localparam logic [2:0] MSS_RAM_1024 = 3'h6;

	// rom capacity codes
	localparam logic [3:0] MSS_ROM_8K  = 4'h2;
	localparam logic [3:0] MSS_ROM_16K = 4'h4;
	localparam logic [3:0] MSS_ROM_24K = 4'h6;
	localparam logic [3:0] MSS_ROM_32K = 4'h8;

	// decoded capacities, in bytes
	localparam logic [10:0] MSS_RAM_BYTES_512  = 11'h200;
	localparam logic [10:0] MSS_RAM_BYTES_1024 = 11'h400;
	localparam logic [15:0] MSS_ROM_LIMIT_8K   = 16'h2000;
	localparam logic [15:0] MSS_ROM_LIMIT_16K  = 16'h4000;
	localparam logic [15:0] MSS_ROM_LIMIT_24K  = 16'h6000;
	localparam logic [15:0] MSS_ROM_LIMIT_32K  = 16'h8000;

	// high-speed ram ends just below this address
	localparam logic [15:0] MSS_RAM_TOP = 16'hFF00;

endpackage

// ===== mss_size_decode.sv
// decodes the stored size code into region limits
// assumes the code comes straight from the register flip-flops
`timescale 1ns/1ps
module mss_size_decode (
	input  wire logic [7:0]  code,
	output logic             rom_valid,
	output logic [15:0]      rom_limit,
	output logic             ram_valid,
	output logic [10:0]      ram_bytes
);

	// rom field lookup; prohibited codes give no rom
	always_comb
	begin
		rom_valid = 1'b1;
		case (code[mss_pkg::MSS_ROM_MSB:mss_pkg::MSS_ROM_LSB])
			mss_pkg::MSS_ROM_8K:  rom_limit = mss_pkg::MSS_ROM_LIMIT_8K;
			mss_pkg::MSS_ROM_16K: rom_limit = mss_pkg::MSS_ROM_LIMIT_16K;
			mss_pkg::MSS_ROM_24K: rom_limit = mss_pkg::MSS_ROM_LIMIT_24K;
			mss_pkg::MSS_ROM_32K: rom_limit = mss_pkg::MSS_ROM_LIMIT_32K;
			default:
			begin
				rom_valid = 1'b0;
				rom_limit = 16'h0000;
			end
		endcase
	end

	// ram field lookup; prohibited codes give no ram
	always_comb
	begin
		ram_valid = 1'b1;
		case (code[mss_pkg::MSS_RAM_MSB:mss_pkg::MSS_RAM_LSB])
			mss_pkg::MSS_RAM_512:  ram_bytes = mss_pkg::MSS_RAM_BYTES_512;
			mss_pkg::MSS_RAM_1024: ram_bytes = mss_pkg::MSS_RAM_BYTES_1024;
			default:
			begin
				ram_valid = 1'b0;
				ram_bytes = 11'h000;
			end
		endcase
	end

endmodule

// ===== mss_reg.sv
// memory size select register and address region decode
// assumes a byte-wide cpu bus: one-cycle rd/wr strobes, synchronous inputs
// Functional notes
// - rom and high-speed ram regions are sized from the stored code.
// - the register is reached only by byte-wide cpu accesses.
// - reset loads the register with CFH.
// - the register sits at FFF0H and is readable and writable.
// - bits 7..5 pick ram size (010 512 B, 110 1024 B), bit 4 is zero.
// - bits 3..0 pick rom size 8/16/24/32 KB, other codes prohibited.
`timescale 1ns/1ps
module mss_reg (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	input  wire logic [7:0]  cpu_wdata,
	output logic [7:0]       cpu_rdata,
	output logic             cpu_sel,
	output logic [7:0]       memory_size_control_register,
	output logic             rom_hit,
	output logic             ram_hit,
	output logic             size_prohibited,
	output logic [15:0]      rom_limit,
	output logic [10:0]      ram_bytes
);

	typedef struct packed {
		logic [7:0] size_r;
		logic [7:0] rdata_r;
	} mss_state_s;

	mss_state_s st_r;
	mss_state_s st_nxt;

	logic       hit;
	logic       rom_valid;
	logic       ram_valid;
	logic [15:0] ram_base;

	// register decode; byte-wide bus, so every access is a full byte
	assign hit = (cpu_addr == mss_pkg::MSS_REG_ADDR);
	assign cpu_sel = hit & (cpu_rd | cpu_wr);

	// next state: write keeps prohibited codes so software can see them
	always_comb
	begin
		st_nxt = st_r;
		if (hit && cpu_wr)
		begin
			st_nxt.size_r = cpu_wdata & mss_pkg::MSS_WRITE_MASK;
		end
		if (hit && cpu_rd)
		begin
			st_nxt.rdata_r = st_r.size_r;
		end
		else
		begin
			st_nxt.rdata_r = 8'h00;
		end
	end

	// single state register
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r.size_r  <= mss_pkg::MSS_RESET_VAL;
			st_r.rdata_r <= 8'h00;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign cpu_rdata = st_r.rdata_r;
	assign memory_size_control_register = st_r.size_r;

	mss_size_decode mss_size_decode_inst (
		.code      (st_r.size_r),
		.rom_valid (rom_valid),
		.rom_limit (rom_limit),
		.ram_valid (ram_valid),
		.ram_bytes (ram_bytes)
	);

	// region hits; ram grows downward from the top of ram space
	assign ram_base = mss_pkg::MSS_RAM_TOP - {5'h00, ram_bytes};
	assign rom_hit = rom_valid && (cpu_addr < rom_limit);
	assign ram_hit = ram_valid && (cpu_addr >= ram_base)
		&& (cpu_addr < mss_pkg::MSS_RAM_TOP);
	// reset value is prohibited until software writes a valid code
	assign size_prohibited = !(rom_valid && ram_valid);

	// assertions
	property p_reset_value;
		@(posedge mclk) $rose(resetn) |-> st_r.size_r == 8'hCF;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("size register not CFH after reset");

	property p_write_stores;
		@(posedge mclk) disable iff (!resetn)
		(cpu_wr && cpu_addr == 16'hFFF0) |=>
			st_r.size_r == ($past(cpu_wdata) & 8'hEF);
	endproperty
	a_write_stores: assert property (p_write_stores)
		else $error("write not stored");

	property p_bit4_zero;
		@(posedge mclk) disable iff (!resetn)
		(cpu_rd && cpu_addr == 16'hFFF0) |=> cpu_rdata[4] == 1'b0;
	endproperty
	a_bit4_zero: assert property (p_bit4_zero)
		else $error("bit 4 read as one");

	property p_read_back;
		@(posedge mclk) disable iff (!resetn)
		(cpu_rd && !cpu_wr && cpu_addr == 16'hFFF0) |=>
			cpu_rdata == $past(st_r.size_r);
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("read data wrong");

	property p_hold;
		@(posedge mclk) disable iff (!resetn)
		!(cpu_wr && cpu_addr == 16'hFFF0) |=> $stable(st_r.size_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("register changed without write");

	property p_rom_32k;
		@(posedge mclk) disable iff (!resetn)
		(st_r.size_r[3:0] == 4'h8) |-> (rom_hit == (cpu_addr < 16'h8000));
	endproperty
	a_rom_32k: assert property (p_rom_32k)
		else $error("rom 32K decode wrong");

	property p_rom_8k;
		@(posedge mclk) disable iff (!resetn)
		(st_r.size_r[3:0] == 4'h2) |-> (rom_hit == (cpu_addr < 16'h2000));
	endproperty
	a_rom_8k: assert property (p_rom_8k)
		else $error("rom 8K decode wrong");

	property p_ram_512;
		@(posedge mclk) disable iff (!resetn)
		(st_r.size_r[7:5] == 3'h2) |-> (ram_hit ==
			(cpu_addr >= 16'hFD00 && cpu_addr < 16'hFF00));
	endproperty
	a_ram_512: assert property (p_ram_512)
		else $error("ram 512 decode wrong");

	property p_prohibited_flag;
		@(posedge mclk) disable iff (!resetn)
		(cpu_wr && cpu_addr == 16'hFFF0 && cpu_wdata == 8'hC6)
			|=> !size_prohibited;
	endproperty
	a_prohibited_flag: assert property (p_prohibited_flag)
		else $error("valid code flagged prohibited");

	// remaining legal rom and ram codes; a wrong limit would alias code
	// space onto data space with no other visible symptom
	property p_rom_16k;
		@(posedge mclk) disable iff (!resetn)
		(st_r.size_r[3:0] == 4'h4) |->
			(rom_hit == (cpu_addr < 16'h4000));
	endproperty
	a_rom_16k: assert property (p_rom_16k)
		else $error("rom 16K decode wrong");

	property p_rom_24k;
		@(posedge mclk) disable iff (!resetn)
		(st_r.size_r[3:0] == 4'h6) |->
			(rom_hit == (cpu_addr < 16'h6000));
	endproperty
	a_rom_24k: assert property (p_rom_24k)
		else $error("rom 24K decode wrong");

	property p_ram_1024;
		@(posedge mclk) disable iff (!resetn)
		(st_r.size_r[7:5] == 3'h6) |-> (ram_hit ==
			(cpu_addr >= 16'hFB00 && cpu_addr < 16'hFF00));
	endproperty
	a_ram_1024: assert property (p_ram_1024)
		else $error("ram 1024 decode wrong");

	// a prohibited field must open no region of its own; the other field's
	// region still decodes, so the map can be left half-open
	property p_rom_prohibited;
		@(posedge mclk) disable iff (!resetn)
		!(st_r.size_r[3:0] inside {4'h2, 4'h4, 4'h6, 4'h8}) |->
			(!rom_hit && rom_limit == 16'h0000 && size_prohibited);
	endproperty
	a_rom_prohibited: assert property (p_rom_prohibited)
		else $error("prohibited rom code opened a region");

	property p_ram_prohibited;
		@(posedge mclk) disable iff (!resetn)
		!(st_r.size_r[7:5] inside {3'h2, 3'h6}) |->
			(!ram_hit && ram_bytes == 11'h000 && size_prohibited);
	endproperty
	a_ram_prohibited: assert property (p_ram_prohibited)
		else $error("prohibited ram code opened a region");

	// read data is a one-cycle pulse; an idle bus reads as zero
	property p_rdata_idle;
		@(posedge mclk) disable iff (!resetn)
		!(cpu_rd && cpu_addr == 16'hFFF0) |=> cpu_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not cleared");

	// first edge after release: reset code still flagged, bus quiet
	property p_reset_outputs;
		@(posedge mclk) $rose(resetn) |->
			(cpu_rdata == 8'h00 && size_prohibited);
	endproperty
	a_reset_outputs: assert property (p_reset_outputs)
		else $error("outputs wrong after reset");

	c_write_42: cover property (@(posedge mclk) disable iff (!resetn)
		cpu_wr && cpu_addr == 16'hFFF0 && cpu_wdata == 8'h42);
	c_write_c8: cover property (@(posedge mclk) disable iff (!resetn)
		cpu_wr && cpu_addr == 16'hFFF0 && cpu_wdata == 8'hC8);
	c_read: cover property (@(posedge mclk) disable iff (!resetn)
		cpu_rd && cpu_addr == 16'hFFF0);
	c_write_prohibited: cover property (@(posedge mclk)
		disable iff (!resetn)
		cpu_wr && cpu_addr == 16'hFFF0 && cpu_wdata == 8'hFF);
	c_reset_release: cover property (@(posedge mclk) $rose(resetn));

endmodule

// ===== mss_reg_bench.sv
// self-checking bench for the memory size select register
// assumes mss_reg carries its own assertions; bench drives the cpu side
`timescale 1ns/1ps
module mss_reg_bench;
	logic        mclk;
	logic        resetn;
	logic [15:0] cpu_addr;
	logic        cpu_wr;
	logic        cpu_rd;
	logic [7:0]  cpu_wdata;
	logic [7:0]  cpu_rdata;
	logic        cpu_sel;
	logic [7:0]  msreg;
	logic        rom_hit;
	logic        ram_hit;
	logic        size_prohibited;
	logic [15:0] rom_limit;
	logic [10:0] ram_bytes;
	int          failures;
	int          samples_checked;
	logic [7:0]  codes [4] = '{8'h42, 8'h44, 8'hC6, 8'hC8};
	logic [15:0] limits [4] = '{16'h2000, 16'h4000, 16'h6000, 16'h8000};
	logic [10:0] rams [4] = '{11'h200, 11'h200, 11'h400, 11'h400};

	mss_reg mss_reg_inst (
		.mclk                         (mclk),
		.resetn                       (resetn),
		.cpu_addr                     (cpu_addr),
		.cpu_wr                       (cpu_wr),
		.cpu_rd                       (cpu_rd),
		.cpu_wdata                    (cpu_wdata),
		.cpu_rdata                    (cpu_rdata),
		.cpu_sel                      (cpu_sel),
		.memory_size_control_register (msreg),
		.rom_hit                      (rom_hit),
		.ram_hit                      (ram_hit),
		.size_prohibited              (size_prohibited),
		.rom_limit                    (rom_limit),
		.ram_bytes                    (ram_bytes)
	);

	// 200 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one byte write, strobe held for exactly one edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		cpu_addr  <= a;
		cpu_wdata <= d;
		cpu_wr    <= 1'b1;
		#1;
		check({15'h0000, cpu_sel}, {15'h0000, a == 16'hFFF0});
		@(posedge mclk);
		cpu_wr    <= 1'b0;
		#1;
	endtask

	// one byte read; data is registered at the edge that takes it
	task automatic rd(input logic [7:0] exp);
		@(posedge mclk);
		cpu_addr <= 16'hFFF0;
		cpu_rd   <= 1'b1;
		#1;
		check({15'h0000, cpu_sel}, 16'h0001);
		@(posedge mclk);
		cpu_rd   <= 1'b0;
		#1;
		check({8'h00, cpu_rdata}, {8'h00, exp});
		@(posedge mclk);
		#1;
		check({8'h00, cpu_rdata}, 16'h0000);
	endtask

	// park an address with no strobe and look at the region decode
	task automatic hit(input logic [15:0] a, input logic rh, input logic mh);
		@(posedge mclk);
		cpu_addr <= a;
		@(posedge mclk);
		#1;
		check({14'h0000, rom_hit, ram_hit}, {14'h0000, rh, mh});
		check({15'h0000, cpu_sel}, 16'h0000);
	endtask

	task automatic print_verdict;
		$display("comparisons=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the roughly 53 cycles the tests need
	initial
	begin
		#20000;
		failures++;
		print_verdict();
	end

	initial
	begin
		resetn = 1'b0; cpu_addr = 16'h0000; cpu_wr = 1'b0;
		cpu_rd = 1'b0; cpu_wdata = 8'h00;
		failures = 0;
		samples_checked = 0;
		repeat (5) @(posedge mclk);
		check({8'h00, msreg}, 16'h00CF);
		check({15'h0000, size_prohibited}, 16'h0001);
		resetn <= 1'b1;
		rd(8'hCF);
		// every documented setting, back to back with its read
		for (int i = 0; i < 4; i++)
		begin
			wr(16'hFFF0, codes[i]);
			check(rom_limit, limits[i]);
			check({5'h00, ram_bytes}, {5'h00, rams[i]});
			check({15'h0000, size_prohibited}, 16'h0000);
			check({8'h00, msreg}, {8'h00, codes[i]});
			rd(codes[i]);
		end
		// region edges with 32 KB rom and 1024 B ram below FF00
		hit(16'h7FFF, 1'b1, 1'b0);
		hit(16'h8000, 1'b0, 1'b0);
		hit(16'hFB00, 1'b0, 1'b1);
		hit(16'hFAFF, 1'b0, 1'b0);
		// a neighbour address must leave the register alone
		wr(16'hFFF1, 8'h42);
		rd(8'hC8);
		// prohibited code kept, bit 4 dropped
		wr(16'hFFF0, 8'hFF);
		rd(8'hEF);
		check({15'h0000, size_prohibited}, 16'h0001);
		hit(16'h0000, 1'b0, 1'b0);
		// second reset in mid-run
		@(posedge mclk);
		resetn <= 1'b0;
		#1;
		check({8'h00, msreg}, 16'h00CF);
		@(posedge mclk);
		resetn <= 1'b1;
		rd(8'hCF);
		print_verdict();
	end
endmodule
